/* include/bms_pkg.sv */
// Purpose: shared constants and types for the boot mode sequencer
// Assumes: 125 MHz system clock, byte-wide loader stream
// Notes:   addresses and timing counts of the boot paths
package bms_pkg;
  localparam logic [1:0]  MODE_BYPASS      = 2'h0;
  localparam logic [1:0]  MODE_FLASH       = 2'h1;
  localparam logic [1:0]  MODE_SPI_HOST    = 2'h2;
  localparam logic [1:0]  MODE_SPI_EEPROM  = 2'h3;
  localparam logic [31:0] ADDR_EXT_START   = 32'h2000_0000;
  localparam logic [31:0] ADDR_L1_INSTR    = 32'hffa0_0000;
  localparam logic [31:0] ADDR_CORE_B      = 32'hff60_0000;
  localparam logic [7:0]  EE_READ_CMD      = 8'h03;
  localparam logic [23:0] EE_START_ADDR    = 24'h00_0000;
  localparam logic [3:0]  EXT_SETUP_CYC    = 4'h4;
  localparam logic [3:0]  EXT_ACCESS_CYC   = 4'hf;
  localparam logic [3:0]  EXT_HOLD_CYC     = 4'h3;
  localparam logic [1:0]  FLASH_BANK       = 2'h0;
  localparam int          SYSCFG_HOLD_BIT  = 5;
  localparam int          RSTCFG_SKIP_BIT  = 4;
  localparam int          WAIT_SEL_LSB     = 5;
  localparam int          WAIT_SEL_MSB     = 10;
  localparam int          FIFO_DEPTH       = 8;
  localparam int          SCK_HALF_DIV     = 4;
  localparam logic [7:0]  SCK_HALF_MAX     = 8'(SCK_HALF_DIV - 1);
  localparam logic [2:0]  HDR_BYTES        = 3'h5;
  typedef struct packed {
    logic [31:0] start_addr;
    logic        core_a_run;
    logic        core_b_run;
    logic        ext_16bit;
    logic        use_boot_rom;
  } bms_exec_s;
  typedef struct packed {
    logic [3:0] setup;
    logic [3:0] access;
    logic [3:0] hold;
    logic [1:0] bank;
  } bms_ext_timing_s;
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  data;
  } bms_wr_s;
endpackage

/* design/bms_fifo.sv */
// Purpose: byte fifo between link and loader
// Assumes: single clock, valid/ready handshake
// Notes:   read data registered
`timescale 1ns/10ps
`default_nettype none
module bms_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_wr_data,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  output logic      [WIDTH-1:0] o_rd_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [AW:0]      cnt_r;
  wire              full  = (cnt_r == (AW+1)'(DEPTH));
  wire              empty = (cnt_r == '0);
  wire              push  = i_wr_valid && !full;
  wire              out_free = !o_rd_valid || i_rd_ready;
  wire              pop   = !empty && out_free;
  assign o_wr_ready = !full;
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_r[wptr_r] <= i_wr_data;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wptr_r     <= '0;
      rptr_r     <= '0;
      cnt_r      <= '0;
      o_rd_valid <= 1'b0;
      o_rd_data  <= '0;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r    <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
        o_rd_data <= mem_r[rptr_r];
      end
      if (out_free) begin
        o_rd_valid <= pop;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* design/bms_spi_link.sv */
// Purpose: spi shift engine in the link clock domain
// Assumes: mode 0, msb first; slave clock from host, master clock divided
// Notes:   bytes leave by toggle handshake
`timescale 1ns/10ps
`default_nettype none
module bms_spi_link (
  input  wire logic       i_clk_link,
  input  wire logic       i_rst_link,
  input  wire logic       i_mosi,
  output logic      [7:0] o_byte,
  output logic            o_byte_tgl
);
  logic [2:0] bit_cnt_r;
  logic [6:0] sh_r;
  wire  [7:0] full_byte = {sh_r, i_mosi};
  always_ff @(posedge i_clk_link) begin
    if (i_rst_link) begin
      bit_cnt_r  <= '0;
      sh_r       <= '0;
      o_byte     <= '0;
      o_byte_tgl <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      sh_r      <= full_byte[6:0];
      if (bit_cnt_r == 3'h7) begin
        o_byte     <= full_byte;
        o_byte_tgl <= ~o_byte_tgl;
      end
    end
  end
endmodule
`default_nettype wire

/* design/bms_top.sv */
// Purpose: boot mode sequencer, selects and runs the boot path
// Assumes: loader stream of blocks: addr(4) count(2) flag(2) then data
// Notes:   host link runs on its own clock
// Contract
// - decode boot pins into four boot paths
// - capture pins only on por, software or wake reset
// - bypass fetches from external start, 16-bit
// - slowest external timing: 4/15/3 cycles
// - bypass lets only core a run
// - flash boot uses async bank 0
// - spi host boot: device slave, host master
// - host wait asserted while fifo full; host pauses
// - wait pin chosen by flag bits 10:5; code drives the pin from flag bits 8:5 only
// - eeprom: select flag, read at zero
// - blocked loader: any blocks, own addresses
// - core a starts at l1 instruction sram
// - core b held until config bit 5 cleared
// - skip bit: software reset jumps to l1
// - regulator wake reset starts boot sequence
`timescale 1ns/10ps
`default_nettype none
module bms_top (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst,
  input  wire logic                      i_clk_link,
  input  wire logic                      i_rst_link,
  input  wire logic                      i_por,
  input  wire logic                      i_sw_reset,
  input  wire logic                      i_wake_reset,
  input  wire logic [1:0]                i_boot_select_pins,
  input  wire logic                      i_skip_boot_set,
  input  wire logic [15:0]               i_core_a_system_config,
  input  wire logic                      i_link_mosi,
  input  wire logic                      i_mem_miso,
  input  wire logic [15:0]               i_flash_data,
  input  wire logic                      i_flash_8bit,
  output logic                           o_mem_sck,
  output logic                           o_mem_mosi,
  output logic                           o_eeprom_select_flag,
  output logic [15:0]                    o_host_hold_off_flag,
  output logic [15:0]                    o_host_hold_off_oe,
  output logic [23:0]                    o_flash_addr,
  output logic                           o_flash_rd,
  output bms_pkg::bms_ext_timing_s       o_ext_timing,
  output bms_pkg::bms_wr_s               o_wr,
  output logic                           o_wr_valid,
  output bms_pkg::bms_exec_s             o_exec,
  output logic [1:0]                     o_boot_mode,
  output logic                           o_skip_boot,
  output logic                           o_busy
);
  typedef enum {ST_IDLE, ST_EE_CMD, ST_HDR, ST_DATA, ST_DONE} bms_state_e;
  bms_state_e  state_r;
  bms_state_e  state_nxt;
  logic [1:0]  pins_m_r;
  logic [1:0]  pins_s_r;
  logic [1:0]  mode_r;
  logic        skip_r;
  logic        go_r;
  logic        wait_on_r;
  logic [5:0]  wait_sel_r;
  logic [2:0]  hdr_cnt_r;
  logic [63:0] hdr_r;
  logic [31:0] dst_r;
  logic [15:0] left_r;
  logic        last_r;
  logic        l_tgl_m_r;
  logic        l_tgl_s_r;
  logic        l_tgl_d_r;
  logic [7:0]  l_byte;
  logic        l_tgl;
  logic [5:0]  ee_cnt_r;
  logic [7:0]  ee_div_r;
  logic [7:0]  ee_sh_r;
  logic [2:0]  ee_bit_r;
  logic        ee_byte_vld_r;
  logic [7:0]  ee_byte_r;
  logic        miso_m_r;
  logic        miso_s_r;
  logic        flash_phase_r;
  logic        flash_vld_r;
  logic [7:0]  flash_byte_r;
  logic [16:0] flash_m_r;
  logic [16:0] flash_s_r;
  logic [7:0]  fifo_in;
  logic        fifo_in_vld;
  logic        fifo_in_rdy;
  logic [7:0]  fifo_out;
  logic        fifo_out_vld;
  logic        fifo_out_rdy;
  wire         boot_req   = i_por || i_sw_reset || i_wake_reset;
  wire         skip_now   = i_sw_reset && skip_r && !i_por;
  wire         is_bypass  = mode_r == bms_pkg::MODE_BYPASS;
  wire         is_host    = mode_r == bms_pkg::MODE_SPI_HOST;
  wire         is_ee      = mode_r == bms_pkg::MODE_SPI_EEPROM;
  wire         is_flash   = mode_r == bms_pkg::MODE_FLASH;
  wire         l_evt      = l_tgl_s_r ^ l_tgl_d_r;
  wire         loading    = state_r == ST_HDR || state_r == ST_DATA;
  wire         take       = fifo_out_vld && fifo_out_rdy;
  wire         hdr_done   = take && state_r == ST_HDR && hdr_cnt_r == bms_pkg::HDR_BYTES + 3'h2;
  wire [15:0]  hdr_flag   = {hdr_r[7:0], fifo_out};
  wire         ee_cmd_end = ee_cnt_r == 6'h20;
  wire         ee_tick    = ee_div_r == bms_pkg::SCK_HALF_MAX;
  wire         ee_cmd_bit = ee_cnt_r < 6'h8 ? bms_pkg::EE_READ_CMD[3'h7 - ee_cnt_r[2:0]] :
                            bms_pkg::EE_START_ADDR[5'd23 - 5'(ee_cnt_r - 6'h8)];
  assign fifo_out_rdy = state_r == ST_HDR || (state_r == ST_DATA && left_r != 16'h0);
  assign fifo_in      = is_host ? l_byte : (is_ee ? ee_byte_r : flash_byte_r);
  assign fifo_in_vld  = is_host ? l_evt : (is_ee ? ee_byte_vld_r : flash_vld_r);
  // host link: slave shifter on host clock
  bms_spi_link u_link (
    .i_clk_link (i_clk_link),
    .i_rst_link (i_rst_link),
    .i_mosi     (i_link_mosi),
    .o_byte     (l_byte),
    .o_byte_tgl (l_tgl)
  );
  bms_fifo #(.WIDTH(8), .DEPTH(bms_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk_sys  (i_clk_sys),
    .i_rst      (i_rst),
    .i_wr_data  (fifo_in),
    .i_wr_valid (fifo_in_vld),
    .o_wr_ready (fifo_in_rdy),
    .o_rd_data  (fifo_out),
    .o_rd_valid (fifo_out_vld),
    .i_rd_ready (fifo_out_rdy)
  );
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (go_r && (is_bypass || skip_r)) begin
          state_nxt = ST_DONE;
        end else if (go_r && is_ee) begin
          state_nxt = ST_EE_CMD;
        end else if (go_r) begin
          state_nxt = ST_HDR;
        end
      end
      ST_EE_CMD: begin
        if (ee_cmd_end) begin
          state_nxt = ST_HDR;
        end
      end
      ST_HDR: begin
        if (hdr_done) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        if (left_r == 16'h0) begin
          state_nxt = last_r ? ST_DONE : ST_HDR;
        end
      end
      ST_DONE: begin
        state_nxt = ST_DONE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end
  // pin sync and reset-time capture
  always_ff @(posedge i_clk_sys) begin
    pins_m_r  <= i_boot_select_pins;
    pins_s_r  <= pins_m_r;
    miso_m_r  <= i_mem_miso;
    miso_s_r  <= miso_m_r;
    flash_m_r <= {i_flash_8bit, i_flash_data};
    flash_s_r <= flash_m_r;
    l_tgl_m_r <= l_tgl;
    l_tgl_s_r <= l_tgl_m_r;
    l_tgl_d_r <= l_tgl_s_r;
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mode_r  <= bms_pkg::MODE_BYPASS;
      skip_r  <= 1'b0;
      go_r    <= 1'b0;
      state_r <= ST_IDLE;
    end else begin
      go_r <= boot_req;
      if (i_por) begin
        skip_r <= 1'b0;
      end else if (i_skip_boot_set) begin
        skip_r <= 1'b1;
      end
      if (i_por || (i_sw_reset && !skip_now) || i_wake_reset) begin
        mode_r <= pins_s_r;
      end
      if (boot_req) begin
        state_r <= ST_IDLE;
      end else begin
        state_r <= state_nxt;
      end
    end
  end
  // loader header and block data
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || boot_req) begin
      hdr_cnt_r  <= '0;
      hdr_r      <= '0;
      dst_r      <= '0;
      left_r     <= '0;
      last_r     <= 1'b0;
      wait_on_r  <= 1'b0;
      wait_sel_r <= '0;
      o_wr       <= '0;
      o_wr_valid <= 1'b0;
    end else begin
      o_wr_valid <= 1'b0;
      if (take && state_r == ST_HDR) begin
        hdr_r     <= {hdr_r[55:0], fifo_out};
        hdr_cnt_r <= hdr_cnt_r + 3'h1;
      end
      if (hdr_done) begin
        hdr_cnt_r  <= '0;
        dst_r      <= hdr_r[55:24];
        left_r     <= hdr_r[23:8];
        last_r     <= hdr_flag[15];
        wait_on_r  <= is_host;
        wait_sel_r <= hdr_flag[bms_pkg::WAIT_SEL_MSB:bms_pkg::WAIT_SEL_LSB];
      end
      if (take && state_r == ST_DATA && left_r != 16'h0) begin
        o_wr       <= '{addr: dst_r, data: fifo_out};
        o_wr_valid <= 1'b1;
        dst_r      <= dst_r + 32'h1;
        left_r     <= left_r - 16'h1;
      end
    end
  end
  // eeprom master: command, address zero, then stream
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || boot_req) begin
      ee_cnt_r             <= '0;
      ee_div_r             <= '0;
      ee_sh_r              <= '0;
      ee_bit_r             <= '0;
      ee_byte_vld_r        <= 1'b0;
      ee_byte_r            <= '0;
      o_mem_sck            <= 1'b0;
      o_mem_mosi           <= 1'b0;
      o_eeprom_select_flag <= 1'b1;
    end else begin
      ee_byte_vld_r <= 1'b0;
      if (is_ee && (state_r == ST_EE_CMD || loading) && fifo_in_rdy) begin
        o_eeprom_select_flag <= 1'b0;
        ee_div_r <= ee_tick ? 8'h0 : ee_div_r + 8'h1;
        if (!o_mem_sck && state_r == ST_EE_CMD && !ee_cmd_end) begin
          o_mem_mosi <= ee_cmd_bit;
        end
        if (ee_tick) begin
          o_mem_sck <= ~o_mem_sck;
          if (o_mem_sck && state_r == ST_EE_CMD) begin
            ee_cnt_r <= ee_cnt_r + 6'h1;
          end
          if (!o_mem_sck && state_r != ST_EE_CMD) begin
            ee_sh_r  <= {ee_sh_r[6:0], miso_s_r};
            ee_bit_r <= ee_bit_r + 3'h1;
            if (ee_bit_r == 3'h7) begin
              ee_byte_r     <= {ee_sh_r[6:0], miso_s_r};
              ee_byte_vld_r <= 1'b1;
            end
          end
        end
      end else if (state_r == ST_DONE) begin
        o_eeprom_select_flag <= 1'b1;
        o_mem_sck            <= 1'b0;
      end
    end
  end
  // flash reader: bank 0, byte or half-word
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || boot_req) begin
      o_flash_addr  <= '0;
      o_flash_rd    <= 1'b0;
      flash_phase_r <= 1'b0;
      flash_vld_r   <= 1'b0;
      flash_byte_r  <= '0;
    end else begin
      flash_vld_r <= 1'b0;
      o_flash_rd  <= is_flash && loading;
      if (is_flash && loading && fifo_in_rdy && !flash_vld_r) begin
        flash_vld_r  <= 1'b1;
        flash_byte_r <= (flash_s_r[16] || !flash_phase_r) ? flash_s_r[7:0] : flash_s_r[15:8];
        if (flash_s_r[16] || flash_phase_r) begin
          o_flash_addr <= o_flash_addr + 24'h1;
        end
        flash_phase_r <= !flash_s_r[16] && !flash_phase_r;
      end
    end
  end
  // host wait drive and exec control
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_host_hold_off_flag <= '0;
      o_host_hold_off_oe   <= '0;
      o_ext_timing         <= '0;
      o_exec               <= '0;
      o_boot_mode          <= '0;
      o_skip_boot          <= 1'b0;
      o_busy               <= 1'b0;
    end else begin
      o_boot_mode <= mode_r;
      o_skip_boot <= skip_r;
      o_busy      <= state_r != ST_DONE;
      o_host_hold_off_oe   <= wait_on_r ? 16'h1 << wait_sel_r[3:0] : 16'h0;
      o_host_hold_off_flag <= (wait_on_r && !fifo_in_rdy) ? 16'h1 << wait_sel_r[3:0] : 16'h0;
      o_ext_timing <= '{setup: bms_pkg::EXT_SETUP_CYC, access: bms_pkg::EXT_ACCESS_CYC,
                        hold: bms_pkg::EXT_HOLD_CYC, bank: bms_pkg::FLASH_BANK};
      o_exec.use_boot_rom <= !is_bypass && !skip_r;
      o_exec.ext_16bit    <= is_bypass;
      if (state_r == ST_DONE && !boot_req) begin
        o_exec.core_a_run <= 1'b1;
        o_exec.start_addr <= (is_bypass && !skip_r) ? bms_pkg::ADDR_EXT_START : bms_pkg::ADDR_L1_INSTR;
        o_exec.core_b_run <= !is_bypass && !i_core_a_system_config[bms_pkg::SYSCFG_HOLD_BIT];
      end else begin
        o_exec <= '0;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/bms_host_model.sv */
// Purpose: spi host feeding the slave boot link
// Assumes: mode 0, msb first, clock still between bytes
// Notes:   pauses while any driven hold-off pin is high
`timescale 1ns/10ps
`default_nettype none
module bms_host_model (
  output logic             o_clk_link,
  output logic             o_mosi,
  input  wire logic [15:0] i_hold,
  input  wire logic [15:0] i_hold_oe
);
  initial begin
    o_clk_link = 1'b0;
    o_mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) begin
      #62.5 o_clk_link = 1'b1;
      #62.5 o_clk_link = 1'b0;
    end
  endtask
  task automatic send(input logic [7:0] b);
    int w;
    w = 0;
    while ((|(i_hold & i_hold_oe)) && w < 20000) begin
      #10 w++;
    end
    for (int i = 7; i >= 0; i--) begin
      o_mosi = b[i];
      tick(1);
    end
    o_mosi = ~b[0];
    #250;
  endtask
endmodule
`default_nettype wire

/* tb/bms_top_asserts.sv */
// Purpose: port checks for the boot mode sequencer
// Assumes: one system clock domain
// Notes:   bound into bms_top
`timescale 1ns/10ps
`default_nettype none
module bms_top_chk (
  input wire logic                     i_clk_sys,
  input wire logic                     i_rst,
  input wire logic                     i_por,
  input wire logic                     i_sw_reset,
  input wire logic                     i_wake_reset,
  input wire logic [15:0]              i_core_a_system_config,
  input wire logic                     o_eeprom_select_flag,
  input wire logic [15:0]              o_host_hold_off_flag,
  input wire logic [15:0]              o_host_hold_off_oe,
  input wire bms_pkg::bms_ext_timing_s o_ext_timing,
  input wire logic                     o_wr_valid,
  input wire bms_pkg::bms_exec_s       o_exec,
  input wire logic [1:0]               o_boot_mode,
  input wire logic                     o_skip_boot,
  input wire logic                     o_busy
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  slow_timing_a: assert property (
    !o_busy && o_exec.core_a_run && o_boot_mode < 2'h2 && $stable(o_boot_mode)
    |-> o_ext_timing == {4'h4, 4'hf, 4'h3, 2'h0}) else $error("ext timing wrong");
  bypass_exec_a: assert property (
    !o_busy && o_exec.core_a_run && o_boot_mode == 2'h0 && $past(o_boot_mode, 6) == 2'h0
    |-> o_exec == {32'h2000_0000, 4'ha}) else $error("bypass exec wrong");
  l1_start_a: assert property (
    !o_busy && o_exec.core_a_run && o_boot_mode != 2'h0
    && $past(o_boot_mode, 6) == o_boot_mode
    |-> o_exec.start_addr == 32'hffa0_0000) else $error("l1 start wrong");
  core_b_hold_a: assert property (
    i_core_a_system_config[5] [*3] |=> !o_exec.core_b_run) else $error("core b ran");
  core_b_after_a: assert property (
    o_exec.core_b_run |-> o_exec.core_a_run) else $error("core b before a");
  select_idle_a: assert property (
    (o_boot_mode != 2'h3) [*3] |-> o_eeprom_select_flag) else $error("select low");
  hold_off_pin_a: assert property (
    $onehot0(o_host_hold_off_flag)
    && (o_host_hold_off_flag & ~o_host_hold_off_oe) == 16'h0) else $error("hold pin");
  write_busy_a: assert property (
    o_wr_valid |-> o_busy && o_boot_mode != 2'h0) else $error("write outside load");
  bypass_run_a: assert property (
    (i_por || i_wake_reset) ##2 o_boot_mode == 2'h0 |-> ##[1:12] o_exec.core_a_run)
    else $error("bypass start late");
  skip_mode_a: assert property (
    i_sw_reset && o_skip_boot |=> $stable(o_boot_mode) [*4]) else $error("mode recaptured");
  por_clear_a: assert property (
    i_por |-> ##[1:3] !o_skip_boot) else $error("skip kept");
  mode_hold_a: assert property (
    !(i_por || i_sw_reset || i_wake_reset) [*4] |=> $stable(o_boot_mode))
    else $error("mode changed");
endmodule
bind bms_top bms_top_chk chk_u (.*);
`default_nettype wire

/* tb/bms_top_tb.sv */
// Purpose: directed bench for the boot mode sequencer
// Assumes: host model feeds the slave link
// Notes:   eeprom and flash paths observed, not completed
`timescale 1ns/10ps
`default_nettype none
module bms_top_tb;
  logic                     clk, rst, rst_l, miso, f8;
  logic [3:0]               req;
  logic [1:0]               pins;
  logic [15:0]              cfg, fdat;
  logic [31:0]              cmd;
  wire logic                clk_l, mosi_l, sck, mosi_m, sel, frd, wr_v, skip, busy;
  wire logic [15:0]         hold, hold_oe;
  wire logic [23:0]         faddr;
  wire logic [1:0]          mode;
  bms_pkg::bms_ext_timing_s tim;
  bms_pkg::bms_wr_s         wr;
  bms_pkg::bms_exec_s       ex;
  bms_pkg::bms_wr_s         wq[$];
  int                       error_cnt, checks_done;
  logic [7:0]               img [19] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h02, 8'h00,
    8'h60, 8'ha5, 8'h5a, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h01, 8'h80, 8'h60, 8'h3c};
  logic [39:0]              exp_w [3] = '{40'h00000100a5, 40'h000001015a, 40'h000002003c};
  bms_host_model host_u (.o_clk_link(clk_l), .o_mosi(mosi_l), .i_hold(hold),
    .i_hold_oe(hold_oe));
  bms_top dut_u (.i_clk_sys(clk), .i_rst(rst), .i_clk_link(clk_l), .i_rst_link(rst_l),
    .i_por(req[0]), .i_sw_reset(req[1]), .i_wake_reset(req[2]), .i_skip_boot_set(req[3]),
    .i_boot_select_pins(pins), .i_core_a_system_config(cfg), .i_link_mosi(mosi_l),
    .i_mem_miso(miso), .i_flash_data(fdat), .i_flash_8bit(f8), .o_mem_sck(sck),
    .o_mem_mosi(mosi_m), .o_eeprom_select_flag(sel), .o_host_hold_off_flag(hold),
    .o_host_hold_off_oe(hold_oe), .o_flash_addr(faddr), .o_flash_rd(frd),
    .o_ext_timing(tim), .o_wr(wr), .o_wr_valid(wr_v), .o_exec(ex), .o_boot_mode(mode),
    .o_skip_boot(skip), .o_busy(busy));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wr_v === 1'b1) begin
      wq.push_back(wr);
    end
  end
  task automatic wrap_up;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(input int k);
    @(negedge clk);
    req = 4'h1 << k;
    @(negedge clk);
    req = 4'h0;
  endtask
  task automatic do_reset;
    @(negedge clk);
    rst = 1'b1;
    rst_l = 1'b1;
    cyc(8);
    rst = 1'b0;
    host_u.tick(3);
    rst_l = 1'b0;
    cyc(4);
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    cyc(4);
    while (!(busy === 1'b0 && ex.core_a_run === 1'b1) && n < 5000) begin
      cyc(1);
      n++;
    end
    chk("boot done", 1'b1, n < 5000);
    cyc(8);
  endtask
  initial begin
    #500000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    rst_l = 1'b1;
    req = 4'h0;
    pins = bms_pkg::MODE_BYPASS;
    cfg = 16'h0;
    fdat = 16'h0;
    miso = 1'b0;
    f8 = 1'b0;
    cmd = 32'h0;
    error_cnt = 0;
    checks_done = 0;
    do_reset();
    chk("select idle", 1'b1, sel);
    pulse(0);
    wait_done();
    chk("mode", bms_pkg::MODE_BYPASS, mode);
    chk("start", bms_pkg::ADDR_EXT_START, ex.start_addr);
    chk("flags", 4'ha, {ex.core_a_run, ex.core_b_run, ex.ext_16bit, ex.use_boot_rom});
    chk("timing", 14'h13cc, tim);
    pins = bms_pkg::MODE_SPI_HOST;
    cyc(8);
    chk("mode kept", bms_pkg::MODE_BYPASS, mode);
    cfg = 16'h0020;
    pulse(0);
    for (int i = 0; i < 19; i++) begin
      host_u.send(img[i]);
      if (i == 8) begin
        cyc(1);
        chk("wait pin oe", 1'b1, hold_oe[3]);
      end
    end
    wait_done();
    chk("writes", 40'd3, wq.size());
    for (int i = 0; i < 3 && i < wq.size(); i++) begin
      chk("write", exp_w[i], wq[i]);
    end
    chk("start", bms_pkg::ADDR_L1_INSTR, ex.start_addr);
    chk("core b held", 1'b0, ex.core_b_run);
    cfg = 16'h0;
    cyc(6);
    chk("core b run", 1'b1, ex.core_b_run);
    chk("mode", bms_pkg::MODE_SPI_HOST, mode);
    pulse(3);
    cyc(2);
    chk("skip set", 1'b1, skip);
    pins = bms_pkg::MODE_SPI_EEPROM;
    cyc(4);
    pulse(1);
    wait_done();
    chk("mode kept", bms_pkg::MODE_SPI_HOST, mode);
    chk("start", bms_pkg::ADDR_L1_INSTR, ex.start_addr);
    pins = bms_pkg::MODE_FLASH;
    cyc(4);
    pulse(0);
    cyc(20);
    chk("skip clear", 1'b0, skip);
    chk("mode", bms_pkg::MODE_FLASH, mode);
    chk("timing", 14'h13cc, tim);
    chk("flash read", 1'b1, frd);
    chk("flash addr", 1'b1, faddr != 24'h0);
    do_reset();
    pins = bms_pkg::MODE_SPI_EEPROM;
    cyc(4);
    pulse(0);
    for (int i = 0; i < 32; i++) begin
      @(posedge sck);
      cmd = {cmd[30:0], mosi_m};
    end
    cyc(1);
    chk("read cmd", {bms_pkg::EE_READ_CMD, bms_pkg::EE_START_ADDR}, cmd);
    chk("select", 1'b0, sel);
    chk("mode", bms_pkg::MODE_SPI_EEPROM, mode);
    do_reset();
    pins = bms_pkg::MODE_BYPASS;
    cyc(4);
    pulse(2);
    wait_done();
    chk("wake start", bms_pkg::ADDR_EXT_START, ex.start_addr);
    wrap_up();
  end
endmodule
`default_nettype wire
